/* include/gwled_map.vh */
/*
 Timing and code constants for the gateway indicator block.
 Assumes a 200 MHz system clock; included by the indicator logic, the checker and the bench.
*/
`ifndef GWLED_MAP_VH
`define GWLED_MAP_VH
// System clock rate in Hz
`define GWLED_CLK_HZ 200000000
// Timebase tick period in microseconds, and its cycle count
`define GWLED_TICK_US 1000
`define GWLED_TICK_CYC (`GWLED_CLK_HZ / 1000000 * `GWLED_TICK_US)
// Lamp-test phase: half a second, in ms
`define GWLED_PHASE_MS 500
// Event flash on-time, ms
`define GWLED_FLASH_MS 50
// Wink half period, ms, and number of alternations
`define GWLED_WINK_MS 250
`define GWLED_WINK_COUNT 10
// Heartbeat period (2 to 3 s) and off blip, ms
`define GWLED_BEAT_MS 2500
`define GWLED_BLIP_MS 100
// Extra delay of the request/reply lamps on the TCP variant, ms
`define GWLED_TCP_DELAY_MS 5000
// Short start-up flashes of the state lamp before heartbeat
`define GWLED_START_FLASHES 3
// Two-bit colour codes: off, green, red, yellow
`define GWLED_OFF 2'h0
`define GWLED_GREEN 2'h1
`define GWLED_RED 2'h2
`define GWLED_YELLOW 2'h3
// Flasher channel numbers
`define GWLED_CH_TX 0
`define GWLED_CH_RX 1
`define GWLED_CH_REQ 2
`define GWLED_CH_OK 3
`define GWLED_CH_BAD 4
`define GWLED_CH_ETH 5
`define GWLED_CH_SVC 6
`define GWLED_CH_NTX 7
`define GWLED_CH_NRX 8
`define GWLED_CH_ERR 9
`define GWLED_NCH 10
`endif

/* logic/gwled_indicator.v */
/*
 Status-indicator logic for a control-network to Modbus gateway.
 Event inputs are one-cycle pulses and levels from logic on clk; the init
 jumper and the cable-link level come from pins and are synchronised here.
*/
`timescale 1ns/1ps
`include "gwled_map.vh"

// Overview of operation
// R1 - Lamp test: yellow/red half second, then green
// R2 - TCP variant delays request/reply lamps further
// R3 - Wink command enters wink, otherwise normal
// R4 - Wink alternates both network lamps ten times
// R5 - Sent network_variable update flashes data yellow
// R6 - Received network_variable update flashes data green
// R7 - Status red if stopped, green when talking
// R8 - Master request sent flashes request yellow
// R9 - Master reply green good, red exception/timeout
// R10 - Slave request arrival flashes request yellow
// R11 - Slave reply green good, red exception/CRC
// R12 - TCP connect failure: no request, red reply
// R13 - Traffic flashes; solid while server not running
// R14 - Link lamp follows network connection
// R15 - Service message flashes service lamp yellow
// R16 - Network transmit/receive flash traffic lamps green
// R17 - State lamp on, brief off heartbeat
// R18 - Error lamp off, flashes code on fault
// R19 - USB connected lamp green when connected
// R20 - Start-up flashes state/error, then short flashes
// R21 - Init jumper at power-up selects update mode
// R22 - Flashes stretched; new event restarts flash
// R23 - All periods from one prescaled timebase
module gwled_indicator #(
    parameter TCP_VARIANT = 0,
    parameter [27:0] TICK_CYC = `GWLED_TICK_CYC
) (
    input wire clk,
    input wire rst,
    input wire nv_sent,
    input wire nv_recv,
    input wire wink_cmd,
    input wire netproc_running,
    input wire host_link_ok,
    input wire mb_is_master,
    input wire mb_req_sent,
    input wire mb_req_recv,
    input wire mb_reply_good,
    input wire mb_reply_exc,
    input wire mb_timeout,
    input wire mb_crc_err,
    input wire tcp_conn_fail,
    input wire eth_traffic,
    input wire server_running,
    input wire eth_link_pin,
    input wire svc_msg,
    input wire net_tx_msg,
    input wire net_rx_msg,
    input wire hw_fault,
    input wire [3:0] fault_code,
    input wire usb_connected,
    input wire init_jumper_pin,
    output reg [1:0] data_led,
    output reg [1:0] status_led,
    output reg [1:0] req_led,
    output reg [1:0] reply_led,
    output reg eth_traffic_led,
    output reg eth_link_led,
    output reg svc_led,
    output reg net_tx_led,
    output reg net_rx_led,
    output reg state_led,
    output reg error_led,
    output reg usb_led,
    output reg update_mode
);

    // Start-up states, one-hot
    localparam [4:0] ST_RED = 5'h01;
    localparam [4:0] ST_GREEN = 5'h02;
    localparam [4:0] ST_TCPW = 5'h04;
    localparam [4:0] ST_RUN = 5'h08;
    localparam [4:0] ST_UPD = 5'h10;
    // Load values, cut on purpose to the width of the counters that take them
    localparam [31:0] FLASH_LOAD = `GWLED_FLASH_MS;
    localparam [31:0] WINK_LOAD = 2 * `GWLED_WINK_COUNT;
    localparam [31:0] START_LOAD = `GWLED_START_FLASHES;

    reg [27:0] presc;         // Cycle prescaler
    reg tick;                 // One-cycle pulse every millisecond
    reg [12:0] phase_ms;      // Millisecond count within start-up phase
    reg [4:0] state;          // Start-up state
    reg [4:0] wink_left;      // Wink half-periods still to show
    reg [7:0] wink_ms;        // Time within one wink half-period
    reg [11:0] beat_ms;       // Heartbeat position
    reg [2:0] start_flash;    // Short state flashes left after the lamp test
    reg [3:0] code_pos;       // Error code blink slot
    reg [2:0] link_s;         // Pin synchroniser for cable link
    reg [2:0] init_s;         // Pin synchroniser for init jumper
    reg link_lvl;             // Filtered cable link level
    reg init_lvl;             // Filtered jumper level
    reg init_taken;           // Jumper sampled once after reset
    reg init_fitted;          // Jumper level taken early; later fitting is ignored
    wire [`GWLED_NCH-1:0] ev; // Event pulses into the stretchers
    wire [`GWLED_NCH-1:0] fl; // Stretched flashes
    wire lamp_red = (state == ST_RED);
    wire lamp_grn = (state == ST_GREEN);
    wire running = (state == ST_RUN) || (state == ST_TCPW);

    // Master and slave share the request and reply events
    assign ev[`GWLED_CH_TX] = nv_sent; // R5
    assign ev[`GWLED_CH_RX] = nv_recv; // R6
    assign ev[`GWLED_CH_REQ] = mb_is_master ? mb_req_sent : mb_req_recv; // R8 R10
    assign ev[`GWLED_CH_OK] = mb_reply_good; // R9 R11
    // Timeout only as master; CRC only as RTU slave
    assign ev[`GWLED_CH_BAD] = mb_reply_exc | (mb_is_master & mb_timeout) | // R9 R11
        (!mb_is_master & mb_crc_err & (TCP_VARIANT == 0)) |
        (mb_is_master & tcp_conn_fail & (TCP_VARIANT != 0)); // R12
    assign ev[`GWLED_CH_ETH] = eth_traffic; // R13
    assign ev[`GWLED_CH_SVC] = svc_msg; // R15
    assign ev[`GWLED_CH_NTX] = net_tx_msg; // R16
    assign ev[`GWLED_CH_NRX] = net_rx_msg; // R16
    assign ev[`GWLED_CH_ERR] = 1'b0;

    // One millisecond timebase shared by every period
    always @(posedge clk) begin
        if (rst) begin
            presc <= 28'h0000000; // R23
            tick <= 1'b0;
        end else if (presc == TICK_CYC - 28'h0000001) begin
            presc <= 28'h0000000;
            tick <= 1'b1;
        end else begin
            presc <= presc + 28'h0000001;
            tick <= 1'b0;
        end
    end

    // Pin inputs: three stages; a change counts once stages two and three agree
    always @(posedge clk) begin
        if (rst) begin
            link_s <= 3'h0;
            init_s <= 3'h0;
            link_lvl <= 1'b0;
            init_lvl <= 1'b0;
        end else begin
            link_s <= {link_s[1:0], eth_link_pin};
            init_s <= {init_s[1:0], init_jumper_pin};
            if (link_s[1] == link_s[2]) begin
                link_lvl <= link_s[2];
            end
            if (init_s[1] == init_s[2]) begin
                init_lvl <= init_s[2];
            end
        end
    end

    // Flash stretchers, one per event channel; a new event restarts the flash
    genvar gi;
    generate
        for (gi = 0; gi < `GWLED_NCH; gi = gi + 1) begin : g_fl
            reg [7:0] left;
            always @(posedge clk) begin
                if (rst) begin
                    left <= 8'h00;
                end else if (ev[gi]) begin
                    left <= FLASH_LOAD[7:0]; // R22
                end else if (tick && left != 8'h00) begin
                    left <= left - 8'h01;
                end
            end
            assign fl[gi] = (left != 8'h00);
        end
    endgenerate

    // Start-up sequence: lamp test, optional TCP delay, then run or update
    always @(posedge clk) begin
        if (rst) begin
            state <= ST_RED;
            phase_ms <= 13'h0000;
            init_taken <= 1'b0;
            init_fitted <= 1'b0;
        end else begin
            if (tick) begin
                phase_ms <= phase_ms + 13'h0001;
            end
            case (state)
                ST_RED: begin
                    // Jumper is settled by now; take it once
                    if (!init_taken && phase_ms == 13'h0010) begin
                        init_taken <= 1'b1;
                        init_fitted <= init_lvl; // R21
                    end
                    if (phase_ms == `GWLED_PHASE_MS) begin // R1
                        state <= ST_GREEN;
                        phase_ms <= 13'h0000;
                    end
                end
                ST_GREEN: begin
                    if (phase_ms == `GWLED_PHASE_MS) begin // R1
                        phase_ms <= 13'h0000;
                        if (init_fitted) begin
                            state <= ST_UPD; // R21
                        end else if (TCP_VARIANT != 0) begin
                            state <= ST_TCPW; // R2
                        end else begin
                            state <= ST_RUN;
                        end
                    end
                end
                ST_TCPW: begin
                    if (phase_ms == `GWLED_TCP_DELAY_MS) begin // R2
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
                ST_UPD: begin
                    state <= ST_UPD;
                end
                default: begin
                    state <= ST_RED;
                end
            endcase
        end
    end

    // Wink sequencer: ten alternations, then back to normal
    always @(posedge clk) begin
        if (rst) begin
            wink_left <= 5'h00;
            wink_ms <= 8'h00;
        end else if (wink_cmd && running) begin
            wink_left <= WINK_LOAD[4:0]; // R3 R4
            wink_ms <= 8'h00;
        end else if (tick && wink_left != 5'h00) begin
            if (wink_ms == `GWLED_WINK_MS - 1) begin
                wink_ms <= 8'h00;
                wink_left <= wink_left - 5'h01; // R4
            end else begin
                wink_ms <= wink_ms + 8'h01;
            end
        end
    end

    // Heartbeat, start-up flashes and error code timing
    always @(posedge clk) begin
        if (rst) begin
            beat_ms <= 12'h000;
            start_flash <= START_LOAD[2:0];
            code_pos <= 4'h0;
        end else if (tick && state == ST_RUN) begin
            if (beat_ms == `GWLED_BEAT_MS - 1) begin
                beat_ms <= 12'h000;
                if (start_flash != 3'h0) begin
                    start_flash <= start_flash - 3'h1; // R20
                end
                // One code slot per beat period; slot 15 is a gap
                code_pos <= code_pos + 4'h1;
            end else begin
                beat_ms <= beat_ms + 12'h001;
            end
        end
    end

    // Lamp drivers, all registered
    always @(posedge clk) begin
        if (rst) begin
            data_led <= `GWLED_OFF;
            status_led <= `GWLED_OFF;
            req_led <= `GWLED_OFF;
            reply_led <= `GWLED_OFF;
            eth_traffic_led <= 1'b0;
            eth_link_led <= 1'b0;
            svc_led <= 1'b0;
            net_tx_led <= 1'b0;
            net_rx_led <= 1'b0;
            state_led <= 1'b0;
            error_led <= 1'b0;
            usb_led <= 1'b0;
            update_mode <= 1'b0;
        end else if (lamp_red || lamp_grn) begin
            // Front panel lamp test; state and error lamps flash once
            data_led <= lamp_red ? `GWLED_YELLOW : `GWLED_GREEN; // R1
            status_led <= lamp_red ? `GWLED_RED : `GWLED_GREEN; // R1
            req_led <= lamp_red ? `GWLED_YELLOW : `GWLED_GREEN; // R1
            reply_led <= lamp_red ? `GWLED_RED : `GWLED_GREEN; // R1
            eth_traffic_led <= 1'b1;
            eth_link_led <= 1'b1;
            state_led <= lamp_red; // R20
            error_led <= lamp_grn; // R20
            svc_led <= 1'b0;
            net_tx_led <= 1'b0;
            net_rx_led <= 1'b0;
            usb_led <= 1'b0;
        end else begin
            update_mode <= (state == ST_UPD); // R21
            if (wink_left != 5'h00) begin
                data_led <= wink_left[0] ? `GWLED_YELLOW : `GWLED_GREEN; // R4
                status_led <= wink_left[0] ? `GWLED_RED : `GWLED_GREEN; // R4
            end else begin
                // Sent flash wins if both are active
                data_led <= fl[`GWLED_CH_TX] ? `GWLED_YELLOW : // R5
                    (fl[`GWLED_CH_RX] ? `GWLED_GREEN : `GWLED_OFF); // R6
                status_led <= !netproc_running ? `GWLED_RED : // R7
                    (host_link_ok ? `GWLED_GREEN : `GWLED_OFF); // R7
            end
            // TCP variant keeps request/reply dark while delayed
            if (state == ST_RUN) begin
                req_led <= fl[`GWLED_CH_REQ] ? `GWLED_YELLOW : `GWLED_OFF; // R8 R10
                reply_led <= fl[`GWLED_CH_BAD] ? `GWLED_RED : // R9 R11 R12
                    (fl[`GWLED_CH_OK] ? `GWLED_GREEN : `GWLED_OFF);
            end else begin
                req_led <= `GWLED_OFF; // R2
                reply_led <= `GWLED_OFF;
            end
            eth_traffic_led <= !server_running | fl[`GWLED_CH_ETH]; // R13
            eth_link_led <= link_lvl; // R14
            svc_led <= fl[`GWLED_CH_SVC]; // R15
            net_tx_led <= fl[`GWLED_CH_NTX]; // R16
            net_rx_led <= fl[`GWLED_CH_NRX]; // R16
            usb_led <= usb_connected; // R19
            if (start_flash != 3'h0) begin
                // Short flashes: on only in the first 100 ms of each 2500 ms period
                state_led <= (beat_ms < `GWLED_BLIP_MS); // R20
            end else begin
                state_led <= (beat_ms >= `GWLED_BLIP_MS); // R17
            end
            // Code n: blink in slots below n, on for first half of a beat
            error_led <= hw_fault && (code_pos < fault_code) &&
                (beat_ms < (`GWLED_BEAT_MS / 2)); // R18
        end
    end

endmodule

/* verification/gwled_chk.sv */
/*
 Checker for the gateway indicator block: timing of event lamps and of the status, traffic and link lamp levels.
 Sees only the top ports; bound to every instance of the block.
*/
`timescale 1ns/1ps
`include "gwled_map.vh"
module gwled_chk #(
    parameter TCP_VARIANT = 0,
    parameter [27:0] TICK_CYC = 28'h30d40
) (
    input wire clk,
    input wire rst,
    input wire nv_sent,
    input wire nv_recv,
    input wire wink_cmd,
    input wire netproc_running,
    input wire mb_is_master,
    input wire mb_req_sent,
    input wire mb_req_recv,
    input wire mb_reply_exc,
    input wire mb_timeout,
    input wire mb_crc_err,
    input wire server_running,
    input wire eth_link_pin,
    input wire svc_msg,
    input wire [1:0] data_led,
    input wire [1:0] status_led,
    input wire [1:0] req_led,
    input wire [1:0] reply_led,
    input wire eth_traffic_led,
    input wire eth_link_led,
    input wire svc_led
);
    // Lamp test and wink both override normal lamps, so checks wait them out
    // The TCP variant keeps its request and reply lamps dark for a further delay
    localparam logic [31:0] LT = (TCP_VARIANT != 0 ? 32'd6010 : 32'd1010) * TICK_CYC;
    localparam logic [31:0] WK = 32'd5010 * TICK_CYC;
    logic [31:0] up; // Cycles since reset, saturating
    logic [31:0] wk; // Cycles since last wink, saturating
    wire norm = (up > LT) && (wk > WK); // Normal indication expected
    // Helper counters; both saturate so a long run never wraps
    always_ff @(posedge clk) begin
        if (rst) begin
            up <= 32'h0;
            wk <= 32'hffffffff;
        end else begin
            up <= (up == 32'hffffffff) ? up : up + 32'h1;
            wk <= wink_cmd ? 32'h0 : ((wk == 32'hffffffff) ? wk : wk + 32'h1);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_SENT_YEL: assert property (norm && nv_sent |-> ##2 data_led == `GWLED_YELLOW)
        else $error("data lamp not yellow after sent update");
    AST_RECV_LIT: assert property (norm && nv_recv |-> ##2 data_led[0])
        else $error("data lamp dark after received update");
    AST_STAT_RED: assert property ((norm && !netproc_running) [*3] |=> status_led == `GWLED_RED)
        else $error("status lamp not red while stopped");
    AST_REQ_YEL: assert property (norm && (mb_is_master ? mb_req_sent : mb_req_recv) |-> ##2 req_led == `GWLED_YELLOW)
        else $error("request lamp not yellow after request");
    AST_REPLY_RED: assert property (norm && (mb_reply_exc || (mb_is_master ? mb_timeout : (mb_crc_err && TCP_VARIANT == 0))) |-> ##2 reply_led == `GWLED_RED)
        else $error("reply lamp not red after failed reply");
    AST_SVC_HOLD: assert property (norm && svc_msg |-> ##2 svc_led [*8])
        else $error("service flash too short");
    AST_SOLID: assert property ((norm && !server_running) [*3] |=> eth_traffic_led)
        else $error("traffic lamp not solid while server stopped");
    AST_LINK: assert property ((norm && eth_link_pin) [*8] |=> eth_link_led)
        else $error("link lamp dark with cable present");
endmodule

bind gwled_indicator gwled_chk #(.TCP_VARIANT(TCP_VARIANT), .TICK_CYC(TICK_CYC)) gwled_chk_i (.*);

/* verification/gwled_src.sv */
/*
 Event source standing in for the gateway processors and network.
 Pulses change on the falling edge and last one clock cycle.
*/
`timescale 1ns/1ps
module gwled_src (
    input wire logic clk,
    output logic [13:0] ev
);
    initial ev = 14'h0000; // Quiet until asked
    // One-cycle pulse; bit 2 is a wink command from the network
    task automatic pulse(input logic [13:0] mask);
        @(negedge clk);
        ev = mask;
        @(negedge clk);
        ev = 14'h0000; // Released at once so an event counts only once
    endtask
endmodule

/* verification/gwled_indicator_tb_top.sv */
/*
 Self-checking bench for the gateway indicator block.
 Assumes a short tick parameter; event pulses come from the source model.
*/
`timescale 1ns/1ps
`include "gwled_map.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module gwled_indicator_tb_top;
    localparam [27:0] TCK = 28'h2; // Short tick keeps the run brief
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mst = 1'b1; // Modbus role, 1 is master
    logic netproc_running = 1'b1;
    logic server_running = 1'b1;
    logic eth_link_pin = 1'b0;
    logic usb_connected = 1'b0;
    logic init_jumper_pin = 1'b0;
    logic host_link_ok = 1'b1;
    logic hw_fault = 1'b0;
    logic [3:0] fault_code = 4'h0;
    logic [27:0] r; // Current row: role, running, events, expected lamps
    logic [31:0] on_cnt; // Heartbeat on cycles
    logic [31:0] err_on; // Error lamp on cycles
    int err_total = 0;
    int check_count = 0;
    wire [13:0] ev;
    wire [1:0] data_led, status_led, req_led, reply_led;
    wire eth_traffic_led, eth_link_led, svc_led, net_tx_led, net_rx_led;
    wire state_led, error_led, usb_led, update_mode;
    wire [1:0] tcp_req, tcp_reply; // Request and reply lamps of the TCP copy
    wire [11:0] obs = {data_led, status_led, req_led, reply_led, eth_traffic_led, svc_led,
        net_tx_led, net_rx_led};
    wire [16:0] all = {obs, eth_link_led, state_led, error_led, usb_led, update_mode};
    // Rows: idle lamps are status green only while running, status red when stopped; ignored events leave them so
    localparam logic [27:0] ROWS [18] = '{28'hc001d00, 28'hc002500, 28'hc0081c0,
        28'hc020110, 28'hc040120, 28'hc080120, 28'hc100100, 28'hc200100, 28'h40101c0,
        28'h4020110, 28'h4040120, 28'h4100120, 28'h4080100, 28'hc400108, 28'hc800104,
        28'hd000102, 28'he000101, 28'h8000200};
    // Free-running 200 MHz clock
    always #2.5 clk = ~clk;
    gwled_src gwled_src_i (.clk(clk), .ev(ev));
    gwled_indicator #(.TCP_VARIANT(0), .TICK_CYC(TCK)) gwled_indicator_i (
        .clk(clk),
        .rst(rst),
        .nv_sent(ev[0]),
        .nv_recv(ev[1]),
        .wink_cmd(ev[2]),
        .netproc_running(netproc_running),
        .host_link_ok(host_link_ok),
        .mb_is_master(mst),
        .mb_req_sent(ev[3]),
        .mb_req_recv(ev[4]),
        .mb_reply_good(ev[5]),
        .mb_reply_exc(ev[6]),
        .mb_timeout(ev[7]),
        .mb_crc_err(ev[8]),
        .tcp_conn_fail(ev[9]),
        .eth_traffic(ev[10]),
        .server_running(server_running),
        .eth_link_pin(eth_link_pin),
        .svc_msg(ev[11]),
        .net_tx_msg(ev[12]),
        .net_rx_msg(ev[13]),
        .hw_fault(hw_fault),
        .fault_code(fault_code),
        .usb_connected(usb_connected),
        .init_jumper_pin(init_jumper_pin),
        .data_led(data_led),
        .status_led(status_led),
        .req_led(req_led),
        .reply_led(reply_led),
        .eth_traffic_led(eth_traffic_led),
        .eth_link_led(eth_link_led),
        .svc_led(svc_led),
        .net_tx_led(net_tx_led),
        .net_rx_led(net_rx_led),
        .state_led(state_led),
        .error_led(error_led),
        .usb_led(usb_led),
        .update_mode(update_mode)
    );
    // TCP copy on the same stimulus; only its request and reply lamps are compared
    gwled_indicator #(.TCP_VARIANT(1), .TICK_CYC(TCK)) gwled_indicator_tcp_i (
        .clk(clk),
        .rst(rst),
        .nv_sent(ev[0]),
        .nv_recv(ev[1]),
        .wink_cmd(ev[2]),
        .netproc_running(netproc_running),
        .host_link_ok(host_link_ok),
        .mb_is_master(mst),
        .mb_req_sent(ev[3]),
        .mb_req_recv(ev[4]),
        .mb_reply_good(ev[5]),
        .mb_reply_exc(ev[6]),
        .mb_timeout(ev[7]),
        .mb_crc_err(ev[8]),
        .tcp_conn_fail(ev[9]),
        .eth_traffic(ev[10]),
        .server_running(server_running),
        .eth_link_pin(eth_link_pin),
        .svc_msg(ev[11]),
        .net_tx_msg(ev[12]),
        .net_rx_msg(ev[13]),
        .hw_fault(hw_fault),
        .fault_code(fault_code),
        .usb_connected(usb_connected),
        .init_jumper_pin(init_jumper_pin),
        .data_led(),
        .status_led(),
        .req_led(tcp_req),
        .reply_led(tcp_reply),
        .eth_traffic_led(),
        .eth_link_led(),
        .svc_led(),
        .net_tx_led(),
        .net_rx_led(),
        .state_led(),
        .error_led(),
        .usb_led(),
        .update_mode()
    );
    // Wait a number of ticks, ending on a falling edge
    task automatic tick(input int n);
        repeat (n * TCK) @(negedge clk);
    endtask
    // Report counts and end the run
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        `CHK(all, 17'h0)
        rst = 1'b0;
        tick(250);
        `CHK(obs[11:4], 8'hee)
        `CHK(state_led, 1'b1)
        tick(500);
        `CHK(obs[11:4], 8'h55)
        `CHK(error_led, 1'b1)
        tick(350);
        `CHK(update_mode, 1'b0)
        // Each row: set levels, fire the events, check the flash then the idle lamps
        for (int i = 0; i < 18; i++) begin
            r = ROWS[i];
            mst = r[27];
            netproc_running = r[26];
            tick(5);
            gwled_src_i.pulse(r[25:12]);
            repeat (2) @(negedge clk);
            `CHK(obs, r[11:0])
            `CHK({tcp_req, tcp_reply}, 4'h0)
            tick(60);
            `CHK(obs, r[26] ? 12'h100 : 12'h200)
        end
        netproc_running = 1'b1;
        // Running but not talking to the host: status goes dark
        host_link_ok = 1'b0;
        tick(1);
        `CHK(status_led, `GWLED_OFF)
        host_link_ok = 1'b1;
        // Both data events at once, then a restart before the flash runs out
        gwled_src_i.pulse(14'h0003);
        tick(40);
        gwled_src_i.pulse(14'h0001);
        tick(40);
        `CHK(data_led, `GWLED_YELLOW)
        tick(20);
        `CHK(data_led, `GWLED_OFF)
        // Wink: green first, then yellow/red, then normal
        gwled_src_i.pulse(14'h0004);
        tick(125);
        `CHK(obs[11:8], 4'h5)
        tick(250);
        `CHK(obs[11:8], 4'he)
        tick(4700);
        `CHK(obs[11:8], 4'h1)
        // TCP copy, past its delay: requests flash; a failed connect is red only
        gwled_src_i.pulse(14'h0008);
        repeat (2) @(negedge clk);
        `CHK({tcp_req, tcp_reply}, 4'hc)
        tick(60);
        gwled_src_i.pulse(14'h0200);
        repeat (2) @(negedge clk);
        `CHK({tcp_req, tcp_reply}, 4'h2)
        tick(60);
        // Slave CRC error: red on the RTU copy, ignored on the TCP copy
        mst = 1'b0;
        gwled_src_i.pulse(14'h0100);
        repeat (2) @(negedge clk);
        `CHK({tcp_req, tcp_reply}, 4'h0)
        `CHK(reply_led, `GWLED_RED)
        mst = 1'b1;
        // Level-driven lamps
        eth_link_pin = 1'b1;
        server_running = 1'b0;
        usb_connected = 1'b1;
        tick(5);
        `CHK({eth_link_led, eth_traffic_led, usb_led}, 3'h7)
        eth_link_pin = 1'b0;
        server_running = 1'b1;
        tick(60);
        `CHK({eth_link_led, eth_traffic_led}, 2'h0)
        // Heartbeat: one full period holds exactly one off blip
        // Fault code 15 lights the error lamp for half of every slot but the last
        hw_fault = 1'b1;
        fault_code = 4'hf;
        tick(1500);
        on_cnt = 32'h0;
        err_on = 32'h0;
        repeat (2500 * TCK) begin
            @(negedge clk);
            if (state_led === 1'b1) on_cnt++;
            if (error_led === 1'b1) err_on++;
        end
        `CHK(on_cnt, 32'd4800)
        `CHK(err_on, 32'd2500)
        hw_fault = 1'b0;
        tick(1);
        `CHK(error_led, 1'b0)
        // Second reset with the jumper fitted
        init_jumper_pin = 1'b1;
        rst = 1'b1;
        repeat (16) @(negedge clk);
        `CHK(all, 17'h0)
        rst = 1'b0;
        tick(1100);
        `CHK(update_mode, 1'b1)
        give_verdict();
    end
endmodule
